// File: include/dpb_pkg.sv
// Purpose: Constants and types for the display panel bus port
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes: Strobe widths follow the panel's minimum write and read pulse figures
// Notes on behaviour
// - The port drives the 16-bit panel data bus on writes and samples it on reads.
// - The write strobe is low only while outgoing data is on the bus, high otherwise.
// - The read strobe is low only while a read is fetching panel data, high otherwise.
// - Panel select is low for the whole of every access and high between accesses.
// - Register select low addresses index or status, high addresses graphics RAM or data.
// - The panel reset output pulses low after reset and returns high before any access.
// - The converter enable output follows the user's power request, high meaning on.
// - All bus timing is counted on the single device clock.
// - Register select low with read reads status, with write writes the index register.
// - Register select high with read reads graphics RAM, with write writes data.
package dpb_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int NS_PER_S = 1000000000;
  // Minimum pulse times in ns
  localparam int WR_LOW_NS = 50;
  localparam int WR_HIGH_NS = 50;
  localparam int RD_LOW_NS = 150;
  localparam int RD_HIGH_NS = 150;
  localparam int SETUP_NS = 25;
  localparam int RST_LOW_NS = 10000;
  localparam int RST_WAIT_NS = 10000;
  // Least times round up
  localparam int WR_LOW_CYC = (WR_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WR_HIGH_CYC = (WR_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RD_LOW_CYC = (RD_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RD_HIGH_CYC = (RD_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RST_LOW_CYC = (RST_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RST_WAIT_CYC = (RST_WAIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W = 10;
  localparam int DATA_W = 16;
  // Request word: {read, register select, data}
  localparam int REQ_W = DATA_W + 2;
  localparam int REQ_RD_BIT = DATA_W + 1;
  localparam int REQ_SEL_BIT = DATA_W;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    ST_RST_LOW = 3'h0,
    ST_RST_WAIT = 3'h1,
    ST_IDLE = 3'h2,
    ST_SETUP = 3'h3,
    ST_STROBE = 3'h4,
    ST_RECOVER = 3'h5
  } dpb_state_t;
endpackage

// File: rtl/dpb_fifo.sv
// Purpose: Small synchronous FIFO for panel bus requests
// Assumes: Single clock, synchronous active-high reset
// Notes: Depth need not be a power of two; count tracks fill level
`timescale 1ns/10ps
`default_nettype none
module dpb_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dpb_fifo_st_t;

  dpb_fifo_st_t st_r;
  dpb_fifo_st_t st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign o_in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data = mem[st_r.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop)
    begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
    end
    if (push && !pop)
    begin
      st_nxt.cnt = st_r.cnt + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      st_nxt.cnt = st_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Storage needs no reset; valid is gated by the count
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[st_r.wp] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// File: rtl/dpb_port.sv
// Purpose: 80-series 16-bit master port to an external panel controller
// Assumes: Inputs synchronous to I_REF_CLK; panel answers read data within the strobe
// Notes: Requests queue in a 4-word FIFO; read data returns as a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module dpb_port #(
  parameter int RST_LOW_CYCLES = dpb_pkg::RST_LOW_CYC,
  parameter int RST_WAIT_CYCLES = dpb_pkg::RST_WAIT_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic i_REQ_VALID,
  output logic o_REQ_READY,
  input wire logic i_REQ_READ,
  input wire logic i_REQ_REG_SEL,
  input wire logic [dpb_pkg::DATA_W-1:0] i_REQ_DATA,
  output logic o_RD_VALID,
  output logic [dpb_pkg::DATA_W-1:0] o_RD_DATA,
  output logic o_INIT_DONE,
  input wire logic i_HV_ON,
  input wire logic [dpb_pkg::DATA_W-1:0] i_PANEL_DATA,
  output logic [dpb_pkg::DATA_W-1:0] o_PANEL_DATA,
  output logic o_PANEL_DATA_OE,
  output logic o_PANEL_CS_N,
  output logic o_PANEL_WR_N,
  output logic o_PANEL_RD_N,
  output logic o_PANEL_REGISTER_SELECT,
  output logic o_PANEL_RESET_N,
  output logic o_HV_CONVERTER_ENABLE
);
  localparam int CW = dpb_pkg::CNT_W;
  localparam int RLW = 24;

  typedef struct packed {
    dpb_pkg::dpb_state_t state;
    logic [RLW-1:0] rcnt;
    logic [CW-1:0] cnt;
    logic is_read;
    logic [dpb_pkg::DATA_W-1:0] dout;
    logic oe;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic reg_sel;
    logic panel_reset_n;
    logic hv;
    logic rd_valid;
    logic [dpb_pkg::DATA_W-1:0] rd_data;
  } dpb_port_st_t;

  dpb_port_st_t st_r;
  dpb_port_st_t st_nxt;
  logic f_valid;
  logic f_pop;
  logic [dpb_pkg::REQ_W-1:0] f_data;

  dpb_fifo #(
    .WIDTH(dpb_pkg::REQ_W),
    .DEPTH(dpb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_in_valid(i_REQ_VALID),
    .o_in_ready(o_REQ_READY),
    .i_in_data({i_REQ_READ, i_REQ_REG_SEL, i_REQ_DATA}),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_data)
  );

  assign f_pop = f_valid && (st_r.state == dpb_pkg::ST_IDLE);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.hv = i_HV_ON;
    unique case (st_r.state)
      dpb_pkg::ST_RST_LOW:
      begin
        st_nxt.panel_reset_n = 1'b0;
        st_nxt.rcnt = st_r.rcnt + RLW'(1);
        if (st_r.rcnt >= RLW'(RST_LOW_CYCLES - 1))
        begin
          st_nxt.rcnt = '0;
          st_nxt.panel_reset_n = 1'b1;
          st_nxt.state = dpb_pkg::ST_RST_WAIT;
        end
      end
      dpb_pkg::ST_RST_WAIT:
      begin
        // Panel needs settle time before first access
        st_nxt.rcnt = st_r.rcnt + RLW'(1);
        if (st_r.rcnt >= RLW'(RST_WAIT_CYCLES - 1))
        begin
          st_nxt.state = dpb_pkg::ST_IDLE;
        end
      end
      dpb_pkg::ST_IDLE:
      begin
        if (f_valid)
        begin
          st_nxt.is_read = f_data[dpb_pkg::REQ_RD_BIT];
          st_nxt.reg_sel = f_data[dpb_pkg::REQ_SEL_BIT];
          st_nxt.dout = f_data[dpb_pkg::DATA_W-1:0];
          st_nxt.oe = !f_data[dpb_pkg::REQ_RD_BIT];
          st_nxt.cs_n = 1'b0;
          st_nxt.cnt = '0;
          st_nxt.state = dpb_pkg::ST_SETUP;
        end
      end
      dpb_pkg::ST_SETUP:
      begin
        // Data and select settle before the strobe falls
        st_nxt.cnt = st_r.cnt + CW'(1);
        if (st_r.cnt >= CW'(dpb_pkg::SETUP_CYC - 1))
        begin
          st_nxt.cnt = '0;
          st_nxt.wr_n = st_r.is_read;
          st_nxt.rd_n = !st_r.is_read;
          st_nxt.state = dpb_pkg::ST_STROBE;
        end
      end
      dpb_pkg::ST_STROBE:
      begin
        st_nxt.cnt = st_r.cnt + CW'(1);
        if (st_r.cnt >= CW'((st_r.is_read ? dpb_pkg::RD_LOW_CYC : dpb_pkg::WR_LOW_CYC) - 1))
        begin
          st_nxt.cnt = '0;
          st_nxt.wr_n = 1'b1;
          st_nxt.rd_n = 1'b1;
          if (st_r.is_read)
          begin
            // Sample at the rising edge of the read strobe
            st_nxt.rd_data = i_PANEL_DATA;
            st_nxt.rd_valid = 1'b1;
          end
          st_nxt.state = dpb_pkg::ST_RECOVER;
        end
      end
      dpb_pkg::ST_RECOVER:
      begin
        // Data held and select kept one cycle past strobe, then high time
        st_nxt.cnt = st_r.cnt + CW'(1);
        if (st_r.cnt == '0)
        begin
          st_nxt.cs_n = 1'b1;
          st_nxt.oe = 1'b0;
        end
        if (st_r.cnt >= CW'((st_r.is_read ? dpb_pkg::RD_HIGH_CYC : dpb_pkg::WR_HIGH_CYC) - 1))
        begin
          st_nxt.state = dpb_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = dpb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      st_r <= '0;
      st_r.state <= dpb_pkg::ST_RST_LOW;
      st_r.cs_n <= 1'b1;
      st_r.wr_n <= 1'b1;
      st_r.rd_n <= 1'b1;
      st_r.reg_sel <= 1'b1;
      st_r.panel_reset_n <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_RD_VALID = st_r.rd_valid;
  assign o_RD_DATA = st_r.rd_data;
  assign o_INIT_DONE = (st_r.state != dpb_pkg::ST_RST_LOW) && (st_r.state != dpb_pkg::ST_RST_WAIT);
  assign o_PANEL_DATA = st_r.dout;
  assign o_PANEL_DATA_OE = st_r.oe;
  assign o_PANEL_CS_N = st_r.cs_n;
  assign o_PANEL_WR_N = st_r.wr_n;
  assign o_PANEL_RD_N = st_r.rd_n;
  assign o_PANEL_REGISTER_SELECT = st_r.reg_sel;
  assign o_PANEL_RESET_N = st_r.panel_reset_n;
  assign o_HV_CONVERTER_ENABLE = st_r.hv;
endmodule
`default_nettype wire

// File: verif/dpb_panel_model.sv
// Purpose: Panel controller model
// Assumes: Status word fixed by parameter
// Notes: Released bus shows inverted last data
`timescale 1ns/10ps
`default_nettype none
module dpb_panel_model #(
  parameter logic [15:0] STATUS = 16'h5A3C
) (
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic i_reg_sel,
  input wire logic [15:0] i_d,
  output logic [15:0] o_d
);
  logic [15:0] idx_r = 16'h0000;
  logic [15:0] graphics_ram_r = 16'h0000;
  // Latch on strobe release
  always @(posedge i_wr_n)
  begin
    if (!i_cs_n && i_reg_sel) graphics_ram_r <= i_d;
    else if (!i_cs_n) idx_r <= i_d;
  end
  assign o_d = (!i_cs_n && !i_rd_n) ? (i_reg_sel ? graphics_ram_r : STATUS) : ~graphics_ram_r;
endmodule
`default_nettype wire

// File: verif/dpb_port_properties.sv
// Purpose: Bus timing checker
// Assumes: Strobe widths 2 and 6 cycles
// Notes: Bound to dpb_port
`timescale 1ns/10ps
`default_nettype none
module dpb_port_properties (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic i_HV_ON,
  input wire logic o_RD_VALID,
  input wire logic [dpb_pkg::DATA_W-1:0] o_PANEL_DATA,
  input wire logic o_PANEL_DATA_OE,
  input wire logic o_PANEL_CS_N,
  input wire logic o_PANEL_WR_N,
  input wire logic o_PANEL_RD_N,
  input wire logic o_PANEL_REGISTER_SELECT,
  input wire logic o_PANEL_RESET_N,
  input wire logic o_HV_CONVERTER_ENABLE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_strobe_excl: assert property (o_PANEL_WR_N || o_PANEL_RD_N)
    else $error("both strobes low");
  a_rd_release: assert property (!o_PANEL_RD_N |-> !o_PANEL_DATA_OE && !o_PANEL_CS_N)
    else $error("bus driven in read");
  a_wr_drive: assert property (!o_PANEL_WR_N |-> o_PANEL_DATA_OE && !o_PANEL_CS_N
    && $stable(o_PANEL_DATA)) else $error("write data bad");
  a_idle_quiet: assert property (o_PANEL_CS_N |-> o_PANEL_WR_N && o_PANEL_RD_N)
    else $error("strobe without select");
  a_init_hold: assert property (!o_PANEL_RESET_N |-> o_PANEL_CS_N)
    else $error("access in panel reset");
  a_wr_width: assert property ($fell(o_PANEL_WR_N) |-> ##1 !o_PANEL_WR_N ##1 o_PANEL_WR_N)
    else $error("write pulse width");
  a_rd_width: assert property ($fell(o_PANEL_RD_N) |-> ##1
    (!o_PANEL_RD_N)[*5] ##1 o_PANEL_RD_N) else $error("read pulse width");
  a_rd_answer: assert property (o_RD_VALID == $rose(o_PANEL_RD_N))
    else $error("read answer timing");
  a_sel_steady: assert property (!o_PANEL_CS_N && !$past(o_PANEL_CS_N)
    |-> $stable(o_PANEL_REGISTER_SELECT)) else $error("select moved");
  a_hv_follow: assert property (!$past(I_RST)
    |-> o_HV_CONVERTER_ENABLE == $past(i_HV_ON)) else $error("converter enable lag");
  c_read: cover property ($rose(o_RD_VALID));
  c_idx_write: cover property ($fell(o_PANEL_WR_N) && !o_PANEL_REGISTER_SELECT);
  c_init: cover property ($rose(o_PANEL_RESET_N));
endmodule
bind dpb_port dpb_port_properties dpb_port_properties_inst (.I_REF_CLK(I_REF_CLK),
  .I_RST(I_RST), .i_HV_ON(i_HV_ON), .o_RD_VALID(o_RD_VALID), .o_PANEL_DATA(o_PANEL_DATA),
  .o_PANEL_DATA_OE(o_PANEL_DATA_OE), .o_PANEL_CS_N(o_PANEL_CS_N), .o_PANEL_WR_N(o_PANEL_WR_N),
  .o_PANEL_RD_N(o_PANEL_RD_N), .o_PANEL_REGISTER_SELECT(o_PANEL_REGISTER_SELECT),
  .o_PANEL_RESET_N(o_PANEL_RESET_N), .o_HV_CONVERTER_ENABLE(o_HV_CONVERTER_ENABLE));
`default_nettype wire

// File: verif/dpb_port_tb.sv
// Purpose: Self-checking bench for dpb_port
// Assumes: Reset counts shortened to 40
// Notes: Requests queued before init fill the FIFO
`timescale 1ns/10ps
`default_nettype none
module dpb_port_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  logic hv = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic rdy, rvld, done, oe, cs_n, wr_n, rd_n, rsel, pnl_rst_n, hv_en;
  logic [15:0] rdat, pout, pin, mout;
  int miscompares = 0;
  int n_checks = 0;
  // Shared bus: design drives only with enable high
  assign pin = oe ? pout : mout;
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  dpb_port #(.RST_LOW_CYCLES(40), .RST_WAIT_CYCLES(40)) dpb_port_inst (.I_REF_CLK(ref_clk),
    .I_RST(rst), .i_REQ_VALID(vld), .o_REQ_READY(rdy), .i_REQ_READ(rd), .i_REQ_REG_SEL(sel),
    .i_REQ_DATA(wd), .o_RD_VALID(rvld), .o_RD_DATA(rdat), .o_INIT_DONE(done), .i_HV_ON(hv),
    .i_PANEL_DATA(pin), .o_PANEL_DATA(pout), .o_PANEL_DATA_OE(oe), .o_PANEL_CS_N(cs_n),
    .o_PANEL_WR_N(wr_n), .o_PANEL_RD_N(rd_n), .o_PANEL_REGISTER_SELECT(rsel),
    .o_PANEL_RESET_N(pnl_rst_n), .o_HV_CONVERTER_ENABLE(hv_en));
  dpb_panel_model dpb_panel_model_inst (.i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_reg_sel(rsel), .i_d(pout), .o_d(mout));
  task give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task push(input logic r, input logic s, input logic [15:0] d);
    int n;
    @(negedge ref_clk);
    vld = 1'b1;
    rd = r;
    sel = s;
    wd = d;
    n = 0;
    while (rdy !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    // FIFO never freeing up is a failure
    if (n >= 300)
    begin
      miscompares++;
    end
    @(negedge ref_clk);
    vld = 1'b0;
  endtask
  task rdchk(input logic s, input logic [15:0] e);
    int n;
    push(1'b1, s, 16'h0000);
    n = 0;
    while (rvld !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A missing answer must not pass on stale data
    if (n >= 100)
    begin
      miscompares++;
    end
    chk(rdat, e);
  endtask
  task t_init_fill;
    chk(pnl_rst_n, 1'b0);
    push(1'b0, 1'b0, 16'h0022);
    push(1'b0, 1'b1, 16'hBEEF);
    push(1'b0, 1'b1, 16'h1234);
    push(1'b0, 1'b1, 16'h8001);
    chk(rdy, 1'b0);
    wait (done === 1'b1);
    chk(pnl_rst_n, 1'b1);
    repeat (40) @(negedge ref_clk);
    chk(dpb_panel_model_inst.idx_r, 16'h0022);
    chk(dpb_panel_model_inst.graphics_ram_r, 16'h8001);
  endtask
  task t_read;
    rdchk(1'b0, 16'h5A3C);
    rdchk(1'b1, 16'h8001);
    push(1'b0, 1'b1, 16'h4321);
    rdchk(1'b1, 16'h4321);
  endtask
  task t_hv;
    @(negedge ref_clk);
    hv = 1'b1;
    @(negedge ref_clk);
    chk(hv_en, 1'b1);
    hv = 1'b0;
    @(negedge ref_clk);
    chk(hv_en, 1'b0);
  endtask
  initial
  begin
    #(25 * 5000);
    miscompares++;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    t_init_fill;
    t_read;
    t_hv;
    give_verdict;
  end
endmodule
`default_nettype wire
